/* hdl/nls_init_seq.sv */
// reset and self-test sequencer: runs the test window, then latches the result
// assumes the self-test code input is stable and same-clock at window end
`timescale 1ns/1ps
`default_nettype none
module nls_init_seq import nls_pkg::*; #(
    parameter int unsigned TEST_CYCLES = SELFTEST_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sw_reset,
    input wire logic [3:0] test_code,
    output logic init_done_q,
    output logic [3:0] code_q
);
    typedef enum logic {NLS_TESTING, NLS_READY} nls_init_t;
    nls_init_t state_q;
    logic [31:0] cnt_q;

    // window count restarts on either reset kind
    always_ff @(posedge ref_clk) begin
        if (sys_rst || sw_reset) begin
            state_q <= NLS_TESTING;
            cnt_q <= 32'h00000000;
        end else begin
            unique case (state_q)
                NLS_TESTING: begin
                    if (cnt_q == TEST_CYCLES - 1) begin // RL18
                        state_q <= NLS_READY;
                    end
                    cnt_q <= cnt_q + 32'h00000001;
                end
                NLS_READY: cnt_q <= cnt_q;
            endcase
        end
    end

    // done and result latch in the same edge the window closes
    always_ff @(posedge ref_clk) begin
        if (sys_rst || sw_reset) begin
            init_done_q <= 1'b0;
            code_q <= ST_CODE_PASS;
        end else if (state_q == NLS_TESTING && cnt_q == TEST_CYCLES - 1) begin
            init_done_q <= 1'b1; // RL14
            code_q <= test_code; // RL17
        end
    end
endmodule
`default_nettype wire

/* hdl/nls_list_base.sv */
// one descriptor list base register: readback copy and effective copy
// assumes the owning process state is a same-clock input
`timescale 1ns/1ps
`default_nettype none
module nls_list_base import nls_pkg::*; (
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic wr,
    input wire logic [ADDR_W-1:0] wdata,
    input wire logic [1:0] proc_state,
    output logic [ADDR_W-1:0] shown_q,
    output logic [ADDR_W-1:0] live_q,
    output logic loaded_q,
    output logic load_q
);
    logic ok;

    // acceptance is judged only at write time, so a late stop cannot revive it
    assign ok = (proc_state == PS_STOPPED) || (proc_state == PS_SUSPENDED); // RL8

    // readback always follows the last write, taken or not
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            shown_q <= BASE_RESET; // RL9
        end else if (wr) begin
            shown_q <= wdata; // RL12
        end
    end

    // effective address moves only on an accepted write
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            live_q <= BASE_RESET;
            loaded_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            load_q <= wr && ok;
            if (wr && ok) begin
                live_q <= wdata; // RL10 RL13
                loaded_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* hdl/nls_pkg.sv */
// constants, field layout and carrier types of the list pointer and status registers
// assumes one 40 MHz clock and a host that issues whole longword accesses
// Function
// RL1 - poll write makes receive list be examined
// RL2 - host polls only while reception suspended
// RL3 - host writes ones to reserved poll bits
// RL4 - host keeps descriptor lists longword aligned
// RL5 - octaword alignment advised for speed
// RL6 - transmit ring holds two descriptors minimum
// RL7 - unloaded list base keeps process stopped
// RL8 - base accepted only when stopped or suspended
// RL9 - unwritten base register reads undefined
// RL10 - base holds thirty bit list address
// RL11 - top two base bits read zero
// RL12 - base reads back last written address
// RL13 - address written while running never applies
// RL14 - init done flag, commands ignored before
// RL15 - both processes stopped after initialization
// RL16 - self-test failure sets failed flag
// RL17 - four bit self-test failure code
// RL18 - self-test completes 25 ms after reset
// RL19 - two bit transmit process state field
// RL20 - two bit receive process state field
// RL21 - upper status read-only, lower write-one-clear
// RL22 - slow access done bit, set after reset
// RL23 - poll ignored unless reception suspended
package nls_pkg;
    localparam logic [31:0] ADDR_RX_POLL = 32'h20008008;
    localparam logic [31:0] ADDR_RX_BASE = 32'h2000800C;
    localparam logic [31:0] ADDR_TX_BASE = 32'h20008010;
    localparam logic [31:0] ADDR_STATUS = 32'h20008014;
    localparam int ADDR_W = 30;
    localparam int STS_INIT_BIT = 31;
    localparam int STS_FAIL_BIT = 30;
    localparam int STS_SS_LSB = 26;
    localparam int STS_TX_LSB = 24;
    localparam int STS_RX_LSB = 22;
    localparam int STS_SLOW_BIT = 16;
    localparam int STS_MBO_LSB = 8;
    localparam logic [7:0] STS_MBO_VAL = 8'hFF;
    localparam logic [7:0] STS_EVT_RESET = 8'h00;
    localparam logic [1:0] PS_STOPPED = 2'h0;
    localparam logic [1:0] PS_RUNNING = 2'h1;
    localparam logic [1:0] PS_SUSPENDED = 2'h2;
    localparam logic [3:0] ST_CODE_PASS = 4'h0;
    localparam logic [3:0] ST_CODE_ROM = 4'h1;
    localparam logic [3:0] ST_CODE_RAM = 4'h2;
    localparam logic [3:0] ST_CODE_FILTER = 4'h3;
    localparam logic [3:0] ST_CODE_TX_FIFO = 4'h4;
    localparam logic [3:0] ST_CODE_RX_FIFO = 4'h5;
    localparam logic [3:0] ST_CODE_LOOP = 4'h6;
    localparam int unsigned SELFTEST_TIME_MS = 25;
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned SELFTEST_CYCLES = SELFTEST_TIME_MS * CLK_KHZ;
    localparam logic [ADDR_W-1:0] BASE_RESET = 30'h00000000;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } nls_csr_req_t;

    typedef struct packed {
        logic [1:0] tx;
        logic [1:0] rx;
    } nls_proc_state_t;
endpackage

/* hdl/nls_regs.sv */
// host register bank: receive poll demand, two list bases, controller status
// assumes host longword accesses as one-cycle strobes and same-clock engines
`timescale 1ns/1ps
`default_nettype none
module nls_regs import nls_pkg::*; #(
    parameter int unsigned TEST_CYCLES = SELFTEST_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire nls_csr_req_t csr_req,
    input wire logic sw_reset,
    input wire logic [3:0] test_code,
    input wire nls_proc_state_t proc_state,
    input wire logic tx_start_req,
    input wire logic rx_start_req,
    input wire logic slow_access_start,
    input wire logic slow_access_end,
    input wire logic [7:0] event_set,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic rx_poll_demand,
    output logic [ADDR_W-1:0] rx_list_address,
    output logic [ADDR_W-1:0] tx_list_address,
    output logic rx_list_load,
    output logic tx_list_load,
    output logic rx_start_go,
    output logic tx_start_go,
    output logic init_done_flag
);
    logic init_done_q;
    logic [3:0] code_q;
    logic clr;
    logic wr_ok;
    logic hit_poll;
    logic hit_rxb;
    logic hit_txb;
    logic hit_sts;
    logic [ADDR_W-1:0] rx_shown;
    logic [ADDR_W-1:0] tx_shown;
    logic rx_loaded;
    logic tx_loaded;
    logic rx_load_q;
    logic tx_load_q;
    logic rx_poll_q;
    logic rx_go_q;
    logic tx_go_q;
    logic slow_done_q;
    logic [7:0] evt_q;
    logic [31:0] rd_data_q;
    logic rd_valid_q;
    logic [31:0] status_word;
    logic [1:0] tx_seen;
    logic [1:0] rx_seen;

    // address match kept in one place so reads and writes agree
    function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // reset and self-test sequencer
    nls_init_seq #(.TEST_CYCLES(TEST_CYCLES)) u_init (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sw_reset(sw_reset),
        .test_code(test_code),
        .init_done_q(init_done_q),
        .code_q(code_q)
    );

    // any reset wipes the lists, so both processes restart stopped
    assign clr = sys_rst || sw_reset; // RL15
    // writes are dropped while the sequence runs
    assign wr_ok = csr_req.wr && init_done_q; // RL14
    assign hit_poll = hit(csr_req.addr, ADDR_RX_POLL);
    assign hit_rxb = hit(csr_req.addr, ADDR_RX_BASE);
    assign hit_txb = hit(csr_req.addr, ADDR_TX_BASE);
    assign hit_sts = hit(csr_req.addr, ADDR_STATUS);

    // the process state shown is forced stopped until the test ends
    assign tx_seen = init_done_q ? proc_state.tx : PS_STOPPED;
    assign rx_seen = init_done_q ? proc_state.rx : PS_STOPPED;

    // upper bits of the written word are dropped: the top field reads zero
    nls_list_base u_rx_base (
        .ref_clk(ref_clk),
        .clr(clr),
        .wr(wr_ok && hit_rxb),
        .wdata(csr_req.wdata[ADDR_W-1:0]), // RL11
        .proc_state(rx_seen),
        .shown_q(rx_shown),
        .live_q(rx_list_address),
        .loaded_q(rx_loaded),
        .load_q(rx_load_q)
    );

    nls_list_base u_tx_base (
        .ref_clk(ref_clk),
        .clr(clr),
        .wr(wr_ok && hit_txb),
        .wdata(csr_req.wdata[ADDR_W-1:0]), // RL11
        .proc_state(tx_seen),
        .shown_q(tx_shown),
        .live_q(tx_list_address),
        .loaded_q(tx_loaded),
        .load_q(tx_load_q)
    );

    // poll demand: data bit is don't-care, only suspended reception reacts
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            rx_poll_q <= 1'b0;
        end else begin
            rx_poll_q <= wr_ok && hit_poll && (rx_seen == PS_SUSPENDED); // RL1 RL23
        end
    end

    // start commands pass only once a base address has been taken
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            rx_go_q <= 1'b0;
            tx_go_q <= 1'b0;
        end else begin
            rx_go_q <= rx_start_req && init_done_q && rx_loaded; // RL7
            tx_go_q <= tx_start_req && init_done_q && tx_loaded; // RL7
        end
    end

    // slow access done: set by reset, dropped at start, set at end
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            slow_done_q <= 1'b1; // RL22
        end else if (slow_access_start) begin
            slow_done_q <= 1'b0;
        end else if (slow_access_end) begin
            slow_done_q <= 1'b1; // RL22
        end
    end

    // low event bits are sticky; a new event beats a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            evt_q <= STS_EVT_RESET;
        end else if (wr_ok && hit_sts) begin
            evt_q <= (evt_q & ~csr_req.wdata[7:0]) | event_set; // RL21
        end else begin
            evt_q <= evt_q | event_set;
        end
    end

    // status image: upper half read-only, writes never reach it
    always_comb begin
        status_word = RD_ZERO;
        status_word[STS_INIT_BIT] = init_done_q; // RL14
        status_word[STS_FAIL_BIT] = (code_q != ST_CODE_PASS); // RL16
        status_word[STS_SS_LSB +: 4] = code_q; // RL17
        status_word[STS_TX_LSB +: 2] = tx_seen; // RL19
        status_word[STS_RX_LSB +: 2] = rx_seen; // RL20
        status_word[STS_SLOW_BIT] = slow_done_q; // RL21
        status_word[STS_MBO_LSB +: 8] = STS_MBO_VAL;
        status_word[7:0] = evt_q;
    end

    // read answer one cycle after the strobe; the poll register is write-only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data_q <= RD_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= csr_req.rd;
            if (!csr_req.rd) begin
                rd_data_q <= rd_data_q;
            end else if (hit_rxb) begin
                rd_data_q <= {2'h0, rx_shown}; // RL11 RL12
            end else if (hit_txb) begin
                rd_data_q <= {2'h0, tx_shown}; // RL11 RL12
            end else if (hit_sts) begin
                rd_data_q <= status_word;
            end else begin
                rd_data_q <= RD_ZERO;
            end
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign rx_poll_demand = rx_poll_q;
    assign rx_list_load = rx_load_q;
    assign tx_list_load = tx_load_q;
    assign rx_start_go = rx_go_q;
    assign tx_start_go = tx_go_q;
    assign init_done_flag = init_done_q;

    // checks on the bank's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence rx_base_write_s;
        csr_req.wr && hit_rxb && init_done_q && !sw_reset;
    endsequence

    sequence rx_base_read_s;
        csr_req.rd && hit_rxb && !csr_req.wr && !sw_reset;
    endsequence

    poll_fire_a: assert property ( // RL1
        csr_req.wr && hit_poll && init_done_q && !sw_reset && proc_state.rx == PS_SUSPENDED
        |=> rx_poll_demand)
        else $error("poll write while suspended gave no demand");

    poll_ignored_a: assert property ( // RL23
        csr_req.wr && hit_poll && proc_state.rx != PS_SUSPENDED |=> !rx_poll_demand)
        else $error("poll write outside suspended state was acted on");

    base_accept_a: assert property ( // RL8
        rx_base_write_s ##0 (proc_state.rx != PS_RUNNING && proc_state.rx != 2'h3)
        |=> rx_list_load && rx_list_address == $past(csr_req.wdata[ADDR_W-1:0]))
        else $error("rx base write while idle not accepted");

    base_discard_a: assert property ( // RL13
        rx_base_write_s ##0 proc_state.rx == PS_RUNNING
        |=> !rx_list_load && $stable(rx_list_address))
        else $error("rx base write while running took effect");

    base_readback_a: assert property ( // RL12
        rx_base_write_s ##1 (!csr_req.wr && !sw_reset) ##1 rx_base_read_s
        |=> rd_valid && rd_data == {2'h0, $past(csr_req.wdata[ADDR_W-1:0], 3)})
        else $error("rx base readback not the last written value");

    top_bits_zero_a: assert property ( // RL11
        csr_req.rd && (hit_rxb || hit_txb) |=> rd_data[31:30] == 2'h0)
        else $error("base register top bits not zero");

    start_gate_a: assert property ( // RL7
        rx_start_req && !rx_loaded |=> !rx_start_go)
        else $error("rx start passed without a loaded base");

    init_block_a: assert property ( // RL14
        !init_done_q && csr_req.wr |=> !rx_list_load && !tx_list_load && !rx_poll_demand)
        else $error("command acted on before init done");

    state_field_a: assert property ( // RL19
        csr_req.rd && hit_sts && init_done_q && !sw_reset
        |=> rd_data[STS_TX_LSB +: 2] == $past(proc_state.tx) && rd_data[STS_INIT_BIT])
        else $error("tx state field wrong in status");

    fail_code_a: assert property ( // RL16
        csr_req.rd && hit_sts
        |=> rd_data[STS_FAIL_BIT] == (rd_data[STS_SS_LSB +: 4] != ST_CODE_PASS))
        else $error("failed flag disagrees with completion code");

    slow_done_a: assert property ( // RL22
        slow_access_end && !slow_access_start |=> slow_done_q ##1 (slow_done_q || $past(slow_access_start)))
        else $error("slow access done bit not set after end");

    sticky_set_a: assert property ( // RL21
        event_set[0] && !sw_reset |=> evt_q[0])
        else $error("event lost against a same-cycle clear");

    // transmit side mirrors the receive accept, discard and start gate checks; it has no readback check
    sequence tx_base_write_s;
        csr_req.wr && hit_txb && init_done_q && !sw_reset;
    endsequence

    tx_accept_a: assert property ( // RL8
        tx_base_write_s ##0 (proc_state.tx == PS_STOPPED || proc_state.tx == PS_SUSPENDED)
        |=> tx_list_load && tx_list_address == $past(csr_req.wdata[ADDR_W-1:0]))
        else $error("tx base write while idle not accepted");

    tx_discard_a: assert property ( // RL13
        tx_base_write_s ##0 proc_state.tx == PS_RUNNING
        |=> !tx_list_load && $stable(tx_list_address))
        else $error("tx base write while running took effect");

    tx_gate_a: assert property ( // RL7
        tx_start_req && !tx_loaded |=> !tx_start_go)
        else $error("tx start passed without a loaded base");

    rx_field_a: assert property ( // RL20
        csr_req.rd && hit_sts && init_done_q && !sw_reset
        |=> rd_data[STS_RX_LSB +: 2] == $past(proc_state.rx))
        else $error("rx state field wrong in status");

    init_stopped_a: assert property ( // RL15
        csr_req.rd && hit_sts && !init_done_q
        |=> rd_data[STS_RX_LSB +: 4] == 4'h0 && !rd_data[STS_INIT_BIT])
        else $error("process state not stopped while init runs");

    upper_ro_a: assert property ( // RL21
        csr_req.wr && hit_sts && !sw_reset && !slow_access_start && !slow_access_end
        |=> $stable(slow_done_q) && $stable(code_q) && $stable(init_done_q))
        else $error("status write reached the read-only half");

    evt_clear_a: assert property ( // RL21
        csr_req.wr && hit_sts && init_done_q && !sw_reset && csr_req.wdata[0] && !event_set[0]
        |=> !evt_q[0])
        else $error("write of one did not clear an event");

    slow_reset_a: assert property ( // RL22
        sw_reset |=> slow_done_q)
        else $error("slow access done bit clear after reset");
endmodule
`default_nettype wire

/* testbench/nls_host_model.sv */
// host model: issues longword reads and writes as one-cycle strobes
// assumes the bank answers a read on the same edge that takes the strobe
`timescale 1ns/1ps
`default_nettype none
module nls_host_model import nls_pkg::*; (
    input wire logic ref_clk,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    output var nls_csr_req_t csr_req
);
    // idle bus at time zero
    initial begin
        csr_req = '0;
    end

    // one write; data is scrambled on release so a stale value never looks valid
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        csr_req.wr <= 1'b1;
        csr_req.addr <= addr;
        csr_req.wdata <= data;
        @(posedge ref_clk);
        csr_req.wr <= 1'b0;
        csr_req.wdata <= ~data;
        #1;
    endtask

    // poll demand: reserved bits always written as ones
    task automatic poll(input logic req_bit);
        wr(ADDR_RX_POLL, {31'h7FFFFFFF, req_bit});
    endtask

    // descriptor rings live in host memory; ring sizing never reaches this bus
    // the bench only hands over bases, so no ring is ever built here

    // one read; answer taken once the registered reply has landed
    task automatic rd(input logic [31:0] addr, output logic [31:0] data, output logic vld);
        @(posedge ref_clk);
        csr_req.rd <= 1'b1;
        csr_req.addr <= addr;
        @(posedge ref_clk);
        csr_req.rd <= 1'b0;
        #1;
        data = rd_data;
        vld = rd_valid;
    endtask
endmodule
`default_nettype wire

/* testbench/nls_list_pointer_status_regs_test.sv */
// self-checking bench for the list pointer and status register bank
// assumes a short self-test window so that each restart takes 16 cycles
`timescale 1ns/1ps
`default_nettype none
module nls_list_pointer_status_regs_test import nls_pkg::*;;
    localparam int TC = 16;
    logic ref_clk, sys_rst, sw_reset, tx_start_req, rx_start_req;
    logic slow_access_start, slow_access_end, rd_valid, rx_poll_demand;
    logic rx_list_load, tx_list_load, rx_start_go, tx_start_go, init_done_flag, vv;
    logic [3:0] test_code;
    logic [7:0] event_set;
    logic [31:0] rd_data, rv;
    logic [ADDR_W-1:0] rx_list_address, tx_list_address;
    nls_csr_req_t csr_req;
    nls_proc_state_t proc_state;
    int n_fail = 0;
    int checks = 0;

    nls_regs #(.TEST_CYCLES(TC)) nls_regs_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .csr_req(csr_req),
        .sw_reset(sw_reset), .test_code(test_code), .proc_state(proc_state), .tx_start_req(tx_start_req),
        .rx_start_req(rx_start_req), .slow_access_start(slow_access_start), .slow_access_end(slow_access_end),
        .event_set(event_set), .rd_data(rd_data), .rd_valid(rd_valid), .rx_poll_demand(rx_poll_demand),
        .rx_list_address(rx_list_address), .tx_list_address(tx_list_address), .rx_list_load(rx_list_load),
        .tx_list_load(tx_list_load), .rx_start_go(rx_start_go), .tx_start_go(tx_start_go),
        .init_done_flag(init_done_flag));
    nls_host_model nls_host_model_inst (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .csr_req(csr_req));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    // read through the host and judge both the valid pulse and the data under a mask
    task automatic rdchk(input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp, input string what);
        nls_host_model_inst.rd(addr, rv, vv);
        chk("rd_valid", 32'h00000001, {31'h0, vv});
        chk(what, exp, rv & mask);
    endtask

    // bounded wait for init done; n counts edges from release
    task automatic wait_init(output int n);
        n = 0;
        while (init_done_flag !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 4 * TC) begin
                chk("init_done_flag", 32'h00000001, {31'h0, init_done_flag});
                conclude();
            end
        end
    endtask

    task automatic sw_restart(input logic [3:0] code);
        @(posedge ref_clk);
        sw_reset <= 1'b1;
        test_code <= code;
        @(posedge ref_clk);
        sw_reset <= 1'b0;
        // let the reset edge settle so a stale init done flag is not seen
        #1;
    endtask

    task automatic start_go(input logic exp_rx, input logic exp_tx);
        @(posedge ref_clk);
        rx_start_req <= 1'b1;
        tx_start_req <= 1'b1;
        @(posedge ref_clk);
        rx_start_req <= 1'b0;
        tx_start_req <= 1'b0;
        #1;
        chk("rx_start_go", {31'h0, exp_rx}, {31'h0, rx_start_go});
        chk("tx_start_go", {31'h0, exp_tx}, {31'h0, tx_start_go});
    endtask

    task automatic t_init();
        int n;
        wait_init(n);
        chk("init cycles", TC, n);
        rdchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h8001FF00, "status after init");
        $display("t_init done");
    endtask

    task automatic t_base();
        @(posedge ref_clk);
        proc_state <= '{tx: PS_SUSPENDED, rx: PS_STOPPED};
        nls_host_model_inst.wr(ADDR_RX_BASE, 32'hFFFFFFFC);
        chk("rx_list_load", 32'h1, {31'h0, rx_list_load});
        chk("rx_list_address", 32'h3FFFFFFC, {2'h0, rx_list_address});
        nls_host_model_inst.wr(ADDR_TX_BASE, 32'h12345670);
        chk("tx_list_load", 32'h1, {31'h0, tx_list_load});
        chk("tx_list_address", 32'h12345670, {2'h0, tx_list_address});
        rdchk(ADDR_RX_BASE, 32'hFFFFFFFF, 32'h3FFFFFFC, "rx base readback");
        @(posedge ref_clk);
        proc_state.rx <= PS_RUNNING;
        nls_host_model_inst.wr(ADDR_RX_BASE, 32'h00001000);
        chk("rx_list_load running", 32'h0, {31'h0, rx_list_load});
        rdchk(ADDR_RX_BASE, 32'hFFFFFFFF, 32'h00001000, "rx base after refused write");
        @(posedge ref_clk);
        proc_state.rx <= PS_STOPPED;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("rx_list_address kept", 32'h3FFFFFFC, {2'h0, rx_list_address});
        $display("t_base done");
    endtask

    task automatic t_poll();
        @(posedge ref_clk);
        proc_state.rx <= PS_SUSPENDED;
        nls_host_model_inst.poll(1'b0);
        chk("rx_poll_demand", 32'h1, {31'h0, rx_poll_demand});
        nls_host_model_inst.poll(1'b1);
        chk("rx_poll_demand again", 32'h1, {31'h0, rx_poll_demand});
        @(posedge ref_clk);
        proc_state.rx <= PS_RUNNING;
        nls_host_model_inst.poll(1'b1);
        chk("rx_poll_demand running", 32'h0, {31'h0, rx_poll_demand});
        rdchk(ADDR_RX_POLL, 32'hFFFFFFFF, 32'h00000000, "poll readback");
        @(posedge ref_clk);
        proc_state.rx <= PS_STOPPED;
        $display("t_poll done");
    endtask

    task automatic t_start();
        int n;
        start_go(1'b1, 1'b1);
        sw_restart(4'h0);
        nls_host_model_inst.wr(ADDR_RX_BASE, 32'h00000100);
        chk("rx_list_load during init", 32'h0, {31'h0, rx_list_load});
        rdchk(ADDR_STATUS, 32'h80000000, 32'h00000000, "init flag during init");
        wait_init(n);
        start_go(1'b0, 1'b0);
        nls_host_model_inst.wr(ADDR_RX_BASE, 32'h00000100);
        chk("rx_list_load after init", 32'h1, {31'h0, rx_list_load});
        start_go(1'b1, 1'b0);
        $display("t_start done");
    endtask

    // every failure code is latched with the failed flag
    task automatic t_selftest();
        int n;
        for (int c = 1; c <= 6; c++) begin
            sw_restart(c[3:0]);
            wait_init(n);
            rdchk(ADDR_STATUS, 32'hFC000000, 32'hC0000000 | (c << 26), "self-test code");
        end
        $display("t_selftest done");
    endtask

    task automatic t_status();
        int n;
        sw_restart(4'h0);
        wait_init(n);
        @(posedge ref_clk);
        proc_state <= '{tx: PS_RUNNING, rx: PS_SUSPENDED};
        event_set <= 8'h81;
        slow_access_start <= 1'b1;
        @(posedge ref_clk);
        event_set <= 8'h00;
        slow_access_start <= 1'b0;
        rdchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h8180FF81, "status live");
        nls_host_model_inst.wr(ADDR_STATUS, 32'hFFFF0001);
        rdchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h8180FF80, "status after write");
        @(posedge ref_clk);
        slow_access_end <= 1'b1;
        @(posedge ref_clk);
        slow_access_end <= 1'b0;
        rdchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h8181FF80, "slow access done");
        $display("t_status done");
    endtask

    // main sequence: reset held eight cycles, then the scenarios in order
    initial begin
        sys_rst = 1'b1;
        sw_reset = 1'b0;
        test_code = 4'h0;
        proc_state = '0;
        tx_start_req = 1'b0;
        rx_start_req = 1'b0;
        slow_access_start = 1'b0;
        slow_access_end = 1'b0;
        event_set = 8'h00;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_init();
        t_base();
        t_poll();
        t_start();
        t_selftest();
        t_status();
        conclude();
    end
endmodule
`default_nettype wire
